// file: dec_ctrl.sv
// Decoder mode, FIFO fill, error counters, subcode capture and serial subcode output
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
module dec_ctrl
    import dec_ctrl_pkg::*;
#(
    parameter int LEVEL_W = 10,
    parameter int FIFO_FRAMES = 512,
    parameter int SPEED = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_in,
    input wire logic frame_out,
    input wire logic c1_frame_err,
    input wire logic c2_frame_err,
    input wire logic block_start,
    input wire logic q_byte_valid,
    input wire logic [7:0] q_byte,
    input wire logic q_frame_done,
    input wire logic q_crc_ok,
    input wire logic sub_word_valid,
    input wire logic [6:0] sub_word,
    input wire logic laser_on_in,
    input wire logic write_on_in,
    output logic sub_word_ready,
    output logic serial_subcode_pin,
    output logic laser_on,
    output logic write_on,
    output logic fifo_write_en,
    output logic fifo_read_ok,
    output logic deint_flush,
    output logic [2:0] ecc_passes
);
    localparam int BIT_CYC = BIT_TIME_NS / (SPEED * CLK_PERIOD_NS);
    localparam int DIV_W = $clog2(BIT_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYC - 1);
    localparam logic [LEVEL_W-1:0] LVL_MIN = LEVEL_W'(READ_MIN_FRAMES);
    localparam logic [LEVEL_W-1:0] LVL_TOP = LEVEL_W'(FIFO_FRAMES);

    // Parameters the logic cannot serve
    if (SPEED < 1 || BIT_CYC < 2) begin : speed_chk
        $error("SPEED gives no usable bit time");
    end
    if (FIFO_FRAMES < READ_MIN_FRAMES ||
        FIFO_FRAMES + SHARE_NORMAL >= 2 ** LEVEL_W) begin : depth_chk
        $error("FIFO_FRAMES does not fit LEVEL_W");
    end

    logic [7:0] mode_reg_r;
    dec_mode_t cur_mode_r;
    logic [LEVEL_W-1:0] level_r;
    logic [7:0] err1_r;
    logic [7:0] err2_r;
    sub_flags_t flags_r;
    logic [7:0] q_store_r [Q_BYTES];
    logic [3:0] wr_ptr_r;
    logic [3:0] rd_ptr_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic laser_on_r;
    logic write_on_r;
    logic fifo_write_en_r;
    logic fifo_read_ok_r;
    logic deint_flush_r;
    logic [2:0] ecc_passes_r;

    // Bus decode: reads act at the setup edge, writes at the completing edge
    wire setup = psel && !penable;
    wire done = psel && penable && pready_r;
    wire [7:0] idx = {2'b00, paddr[7:2]};
    wire aligned = paddr[1:0] == 2'b00;
    wire hit_status = aligned && idx == STATUS_IDX;
    wire hit_mode = aligned && idx == MODE_IDX;
    wire hit_rel = aligned && idx == RELEASE_IDX;
    wire hit_level = aligned && idx == LEVEL_IDX;
    wire hit_err1 = aligned && idx == ERR1_IDX;
    wire hit_err2 = aligned && idx == ERR2_IDX;
    wire mapped = hit_status || hit_mode || hit_rel || hit_level || hit_err1 || hit_err2;
    wire rd_status = setup && !pwrite && hit_status;
    wire rd_mode = setup && !pwrite && hit_mode;
    wire rd_rel = setup && !pwrite && hit_rel;
    wire rd_err1 = setup && !pwrite && hit_err1;
    wire rd_err2 = setup && !pwrite && hit_err2;
    wire wr_mode = done && pwrite && hit_mode;
    // Only the mode register takes writes
    wire bad_nxt = !mapped || (pwrite && !hit_mode);

    // Mode decode; hold changes wait for a subcode block start
    wire dec_mode_t req_mode = decode_mode(mode_reg_r[7:MODE_LSB]);
    wire hold_change = (req_mode == M_HOLD) != (cur_mode_r == M_HOLD);
    wire dec_mode_t mode_nxt = (hold_change && !block_start) ? cur_mode_r : req_mode;
    wire playing = cur_mode_r == M_NORMAL || cur_mode_r == M_FAST;
    wire flushing = cur_mode_r == M_FLUSH || cur_mode_r == M_ENCODE;

    // FIFO level; a stored frame leaves only when read-out is allowed
    wire fill = frame_in && playing && level_r != LVL_TOP;
    wire drain = frame_out && fifo_read_ok_r && level_r != '0;
    wire [LEVEL_W-1:0] level_nxt = flushing ? '0 :
        level_r + LEVEL_W'(fill) - LEVEL_W'(drain);
    wire [LEVEL_W-1:0] share = cur_mode_r == M_FAST ? LEVEL_W'(SHARE_FAST) :
        cur_mode_r == M_NORMAL ? LEVEL_W'(SHARE_NORMAL) : '0;
    wire [LEVEL_W-1:0] level_rep = level_r + share;

    // Error counters: a read clears, an event in the same cycle still counts
    wire [7:0] err1_nxt = rd_err1 ? {7'h00, c1_frame_err} :
        (c1_frame_err ? sat_inc(err1_r) : err1_r);
    wire [7:0] err2_nxt = rd_err2 ? {7'h00, c2_frame_err} :
        (c2_frame_err ? sat_inc(err2_r) : err2_r);

    // Read data mux; release and unmapped addresses read zero
    wire [7:0] status_byte = {flags_r.ready, flags_r.busy, flags_r.crc_ok, 5'h00};
    wire [7:0] sub_byte = (flags_r.busy && rd_ptr_r < 4'(Q_BYTES)) ?
        q_store_r[rd_ptr_r] : 8'h00;
    wire [31:0] rd_mux = hit_status ? {24'h0, status_byte} :
        hit_mode ? {24'h0, sub_byte} :
        hit_level ? {{(32 - LEVEL_W){1'b0}}, level_rep} :
        hit_err1 ? {24'h0, err1_r} :
        hit_err2 ? {24'h0, err2_r} : 32'h0;

    // No wait state: data is registered at setup, ready in the first access cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r <= pwrite ? 32'h0 : rd_mux;
                pslverr_r <= bad_nxt;
            end
        end
    end

    // Mode register, effective mode and FIFO level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg_r <= MODE_RESET;
            cur_mode_r <= M_FLUSH;
            level_r <= '0;
        end else begin
            if (wr_mode) mode_reg_r <= pwdata[7:0];
            cur_mode_r <= mode_nxt;
            level_r <= level_nxt;
        end
    end

    // Registered outputs that follow the mode and level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            laser_on_r <= 1'b0;
            write_on_r <= 1'b0;
            fifo_write_en_r <= 1'b0;
            fifo_read_ok_r <= 1'b0;
            deint_flush_r <= 1'b1;
            ecc_passes_r <= 3'h0;
        end else begin
            laser_on_r <= laser_on_in && !mode_reg_r[LASER_RST_BIT];
            write_on_r <= write_on_in && !mode_reg_r[LASER_RST_BIT];
            fifo_write_en_r <= mode_nxt == M_NORMAL || mode_nxt == M_FAST;
            // Hold keeps read-out of what is stored
            fifo_read_ok_r <= mode_nxt != M_FLUSH && mode_nxt != M_ENCODE && level_nxt >= LVL_MIN;
            deint_flush_r <= mode_nxt == M_FLUSH || mode_nxt == M_ENCODE;
            ecc_passes_r <= mode_nxt == M_FAST ? 3'(PASSES_FAST) :
                mode_nxt == M_NORMAL ? 3'(PASSES_NORMAL) : 3'h0;
        end
    end

    // Error counters
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            err1_r <= 8'h00;
            err2_r <= 8'h00;
        end else begin
            err1_r <= err1_nxt;
            err2_r <= err2_nxt;
        end
    end

    // Subcode capture; nothing is written while the buffer is held
    wire cap_byte = q_byte_valid && !flags_r.busy && wr_ptr_r < 4'(Q_BYTES);
    wire cap_done = q_frame_done && !flags_r.busy;
    always_ff @(posedge clock) begin
        if (cap_byte) q_store_r[wr_ptr_r] <= q_byte;
    end

    // Subcode flags and pointers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= '0;
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
        end else if (rd_rel) begin
            // Release frees the buffer and rewinds the read pointer
            flags_r <= '0;
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
        end else begin
            if (rd_status && flags_r.ready) flags_r.busy <= 1'b1;
            if (rd_mode && flags_r.busy && rd_ptr_r < 4'(Q_BYTES))
                rd_ptr_r <= rd_ptr_r + 4'h1;
            if (cap_byte) wr_ptr_r <= wr_ptr_r + 4'h1;
            if (cap_byte && wr_ptr_r == 4'h0) flags_r.ready <= 1'b0;
            if (cap_done) begin
                flags_r.ready <= 1'b1;
                flags_r.crc_ok <= q_crc_ok;
                wr_ptr_r <= 4'h0;
            end
        end
    end

    // Serial subcode output
    typedef enum logic {SER_IDLE, SER_SHIFT} ser_st_t;
    ser_st_t ser_st_r;
    logic [DIV_W-1:0] div_r;
    logic [7:0] shift_r;
    logic [2:0] bit_cnt_r;
    logic [4:0] idle_cnt_r;
    logic sync_pend_r;
    logic [6:0] word_r;
    logic word_free_r;
    logic pin_r;

    // Bit tick divider, one bit time is half a word clock period
    wire bit_tick = div_r == DIV_LAST;
    wire [4:0] need = sync_pend_r ? 5'(SYNC_BITS) : 5'(GAP_BITS);
    wire go = ser_st_r == SER_IDLE && bit_tick && !word_free_r &&
        idle_cnt_r >= need;
    wire last_bit = ser_st_r == SER_SHIFT && bit_tick && bit_cnt_r == 3'(WORD_BITS - 1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) div_r <= '0;
        else div_r <= bit_tick ? '0 : div_r + DIV_W'(1);
    end

    // One-word holding slot; the source stalls on sub_word_ready low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            word_r <= 7'h00;
            word_free_r <= 1'b1;
        end else if (sub_word_valid && word_free_r) begin
            word_r <= sub_word;
            word_free_r <= 1'b0;
        end else if (go) begin
            word_free_r <= 1'b1;
        end
    end

    // A block start during a word forces the long pause after it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) sync_pend_r <= 1'b0;
        else if (block_start) sync_pend_r <= 1'b1;
        else if (go) sync_pend_r <= 1'b0;
    end

    // Word shifter and idle bit counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ser_st_r <= SER_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            idle_cnt_r <= 5'h00;
        end else if (go) begin
            ser_st_r <= SER_SHIFT;
            shift_r <= {1'b1, word_r};
            bit_cnt_r <= 3'h0;
        end else if (last_bit) begin
            ser_st_r <= SER_IDLE;
            idle_cnt_r <= 5'h00;
        end else if (bit_tick && ser_st_r == SER_SHIFT) begin
            shift_r <= {shift_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end else if (bit_tick && idle_cnt_r != 5'h1F) begin
            idle_cnt_r <= idle_cnt_r + 5'h01;
        end
    end

    // Pin register; low while idle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) pin_r <= 1'b0;
        else pin_r <= (go || (ser_st_r == SER_SHIFT && !last_bit)) ?
            (go ? 1'b1 : (bit_tick ? shift_r[6] : shift_r[7])) : 1'b0;
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sub_word_ready = word_free_r;
    assign serial_subcode_pin = pin_r;
    assign laser_on = laser_on_r;
    assign write_on = write_on_r;
    assign fifo_write_en = fifo_write_en_r;
    assign fifo_read_ok = fifo_read_ok_r;
    assign deint_flush = deint_flush_r;
    assign ecc_passes = ecc_passes_r;
endmodule

// file: dec_ctrl_pkg.sv
// Constants, types and helper functions for the decoder control block
// How it works
// - Seven-bit mode field decodes flush, normal, fast, hold, encode; rest reserved.
// - Flush empties deinterleaver storage and discards all incoming decoded data.
// - Normal play selects four-pass correction, for up to 75% speed.
// - Fast play selects two-pass correction, for 25 to 100% speed.
// - Hold stops FIFO writes; header decoding keeps running.
// - Entering or leaving hold takes effect at the next subcode block start.
// - Frame error pulses increment first and second level error counters.
// - Each error counter sticks at 255 instead of wrapping.
// - Reading an error counter returns its value and then clears it.
// - Read-out is allowed only while the FIFO holds at least 110 frames.
// - In hold, frames already stored can still be read out.
// - Play modes keep filling the FIFO; read-out once level suffices.
// - Reported level adds corrector share: 110 fast, 220 normal.
// - Status bits: 7 frame available, 6 held, 5 CRC good.
// - Status read with frame available sets held; held blocks overwrite.
// - While held, mode address reads return successive stored bytes, up to 12.
// - Release address read returns zero and frees the held buffer.
// - Serial subcode word is a 1 then seven bits Q to W.
// - Idle gap between serial words lies between 11.3/n and 90/n us.
// - Serial sync is an idle pause of at least 200/n us.
// - Mode field is bits 7 to 1; bit 0 resets laser and write outputs.
package dec_ctrl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] STATUS_IDX = 8'h12;
    localparam logic [7:0] MODE_IDX = 8'h13;
    localparam logic [7:0] RELEASE_IDX = 8'h14;
    localparam logic [7:0] LEVEL_IDX = 8'h15;
    localparam logic [7:0] ERR1_IDX = 8'h39;
    localparam logic [7:0] ERR2_IDX = 8'h3A;
    // Mode field codes and field positions
    localparam logic [6:0] CODE_FLUSH = 7'h00;
    localparam logic [6:0] CODE_NORMAL = 7'h20;
    localparam logic [6:0] CODE_FAST = 7'h28;
    localparam logic [6:0] CODE_HOLD = 7'h30;
    localparam logic [6:0] CODE_ENCODE = 7'h2A;
    localparam int MODE_LSB = 1;
    localparam int LASER_RST_BIT = 0;
    localparam int READY_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int CRC_BIT = 5;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Counts
    localparam logic [7:0] ERR_MAX = 8'hFF;
    localparam int READ_MIN_FRAMES = 110;
    localparam int SHARE_FAST = 110;
    localparam int SHARE_NORMAL = 220;
    localparam int Q_BYTES = 12;
    localparam int PASSES_NORMAL = 4;
    localparam int PASSES_FAST = 2;
    // Serial subcode timing, ns at speed factor one
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_TIME_NS = 11300;
    localparam int GAP_MIN_NS = 11300;
    localparam int GAP_MAX_NS = 90000;
    localparam int SYNC_MIN_NS = 200000;
    // Gap and sync in bit times: least rounds up, longest rounds down
    localparam int GAP_BITS = (GAP_MIN_NS + BIT_TIME_NS - 1) / BIT_TIME_NS;
    localparam int GAP_MAX_BITS = GAP_MAX_NS / BIT_TIME_NS;
    localparam int SYNC_BITS = (SYNC_MIN_NS + BIT_TIME_NS - 1) / BIT_TIME_NS;
    localparam int WORD_BITS = 8;

    typedef enum logic [2:0] {
        M_FLUSH, M_NORMAL, M_FAST, M_HOLD, M_ENCODE
    } dec_mode_t;

    typedef struct packed {
        logic ready;
        logic busy;
        logic crc_ok;
    } sub_flags_t;

    // Reserved codes fall back to flush
    function automatic dec_mode_t decode_mode(input logic [6:0] code);
        dec_mode_t m;
        m = M_FLUSH;
        if (code == CODE_NORMAL) m = M_NORMAL;
        if (code == CODE_FAST) m = M_FAST;
        if (code == CODE_HOLD) m = M_HOLD;
        if (code == CODE_ENCODE) m = M_ENCODE;
        return m;
    endfunction

    // Saturating step of an error counter
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == ERR_MAX) ? ERR_MAX : v + 8'h01;
    endfunction
endpackage

// file: dec_ctrl_props.sv
// Port checker for the decoder control block
`timescale 1ns/10ps
module dec_ctrl_props
    import dec_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic block_start,
    input wire logic sub_word_valid,
    input wire logic sub_word_ready,
    input wire logic laser_on_in,
    input wire logic laser_on,
    input wire logic fifo_write_en,
    input wire logic fifo_read_ok,
    input wire logic deint_flush,
    input wire logic [2:0] ecc_passes
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic lwc_r;
    logic lwc_nxt;
    // Shadow of the laser reset bit, taken only on a completed mode write
    wire mode_wr = psel && penable && pready && pwrite && paddr == {MODE_IDX[5:0], 2'h0};
    assign lwc_nxt = mode_wr ? pwdata[0] : lwc_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lwc_r <= 1'h0;
        end else begin
            lwc_r <= lwc_nxt;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_setup_s(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    // Write enable moves without a flush only when hold is entered or left
    sequence hold_edge_s;
        ($fell(fifo_write_en) && !deint_flush) || ($rose(fifo_write_en) && !$past(deint_flush));
    endsequence
    pready_timing_a: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    pready_only_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    release_zero_a: assert property (rd_setup_s({RELEASE_IDX[5:0], 2'h0}) |=> prdata == 32'h0)
        else $error("release read not zero");
    status_bits_a: assert property (rd_setup_s({STATUS_IDX[5:0], 2'h0}) |=>
        prdata[31:8] == 24'h0 && prdata[4:0] == 5'h0) else $error("status reserved bits set");
    flush_quiet_a: assert property (deint_flush |->
        !fifo_write_en && !fifo_read_ok && ecc_passes == 3'h0) else $error("flush not quiet");
    play_passes_a: assert property (ecc_passes != 3'h0 |-> fifo_write_en &&
        (ecc_passes == 3'h4 || ecc_passes == 3'h2)) else $error("bad pass count");
    hold_sync_a: assert property (hold_edge_s |-> $past(block_start) || $past(block_start, 2))
        else $error("hold change off block start");
    word_take_a: assert property (sub_word_valid && sub_word_ready |=> !sub_word_ready)
        else $error("word slot not filled");
    laser_reset_a: assert property ($past(rst_n) |-> laser_on == $past(laser_on_in && !lwc_r))
        else $error("laser output wrong");
endmodule
bind dec_ctrl dec_ctrl_props props (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .block_start, .sub_word_valid, .sub_word_ready,
    .laser_on_in, .laser_on, .fifo_write_en, .fifo_read_ok, .deint_flush, .ecc_passes);

// file: apb_host.sv
// Host processor model issuing register transfers on the APB side
`timescale 1ns/10ps
module apb_host (
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // Bus idle at time zero
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Setup, then access held until pready is sampled high; released lines show a new pattern
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clock);
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the decoder control block
`timescale 1ns/10ps
module tb_top;
    import dec_ctrl_pkg::*;
    localparam int BITC = 14; // Serial bit time in cycles at SPEED 100
    logic clock = 1'h0, rst_n = 1'h0, c1_frame_err = 1'h0, c2_frame_err = 1'h0;
    logic q_byte_valid = 1'h0, q_frame_done = 1'h0, q_crc_ok = 1'h0, sub_word_valid = 1'h0;
    logic laser_on_in = 1'h0, write_on_in = 1'h0;
    logic [2:0] pul = 3'h0;
    logic [7:0] q_byte = 8'h00;
    logic [6:0] sub_word = 7'h00;
    logic [7:0] qb [12];
    wire frame_in = pul[0];
    wire frame_out = pul[1];
    wire block_start = pul[2];
    logic psel, penable, pwrite, pready, pslverr, sub_word_ready, serial_subcode_pin;
    logic laser_on, write_on, fifo_write_en, fifo_read_ok, deint_flush;
    logic [2:0] ecc_passes;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int fail_count = 0, comparisons = 0, cycles = 0, low_run = 0;
    dec_ctrl #(.SPEED(100)) dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .frame_in, .frame_out, .c1_frame_err, .c2_frame_err,
        .block_start, .q_byte_valid, .q_byte, .q_frame_done, .q_crc_ok, .sub_word_valid,
        .sub_word, .laser_on_in, .write_on_in, .sub_word_ready, .serial_subcode_pin,
        .laser_on, .write_on, .fifo_write_en, .fifo_read_ok, .deint_flush, .ecc_passes);
    apb_host host (.clock, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
        .pwdata);
    always #4 clock = ~clock;
    // Hang guard above the sequence length; serial pin low run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        low_run <= serial_subcode_pin ? 0 : low_run + 1;
        if (cycles == 40000) begin
            fail_count = fail_count + 1;
            summarize();
        end
    end
    task summarize();
        $display("Checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic bad(input logic [7:0] idx, input logic w);
        return (w && idx != MODE_IDX) ||
            !(idx inside {STATUS_IDX, MODE_IDX, RELEASE_IDX, LEVEL_IDX, ERR1_IDX, ERR2_IDX});
    endfunction
    // Outputs {flush, write enable, passes} that a mode code must give
    function automatic logic [4:0] exp_mode(input logic [6:0] code);
        if (code == CODE_NORMAL) return {2'h1, 3'(PASSES_NORMAL)};
        if (code == CODE_FAST) return {2'h1, 3'(PASSES_FAST)};
        return 5'h10;
    endfunction
    // One register access; the error response is checked on every access
    task automatic acc(input logic [7:0] idx, input logic w, input logic [31:0] d,
                       input logic [31:0] exp, input logic [31:0] msk = 32'hFFFFFFFF);
        logic [31:0] q;
        logic e;
        host.xfer({idx[5:0], 2'h0}, w, d, q, e);
        check($sformatf("reg %0h data", idx), q & msk, exp);
        check($sformatf("reg %0h error", idx), {31'h0, e}, {31'h0, bad(idx, w)});
    endtask
    task automatic wr_mode(input logic [6:0] code, input logic lwc);
        acc(MODE_IDX, 1'h1, {24'h0, code, lwc}, 32'h0, 32'h0);
        repeat (3) @(posedge clock);
    endtask
    task automatic pulse(input int which, input int n);
        pul[which] <= 1'h1;
        repeat (n) @(posedge clock);
        pul[which] <= 1'h0;
        repeat (3) @(posedge clock);
    endtask
    task automatic errs(input int n1, input int n2);
        for (int i = 0; i < 300; i++) begin
            c1_frame_err <= (i < n1);
            c2_frame_err <= (i < n2);
            @(posedge clock);
        end
        c1_frame_err <= 1'h0;
        c2_frame_err <= 1'h0;
        @(posedge clock);
    endtask
    // Twelve Q bytes, then frame end; released byte lines show the inverse
    task automatic send_q(input logic [7:0] mask, input logic crc);
        foreach (qb[i]) begin
            q_byte_valid <= 1'h1;
            q_byte <= qb[i] ^ mask;
            @(posedge clock);
        end
        q_byte_valid <= 1'h0;
        q_byte <= ~q_byte;
        q_frame_done <= 1'h1;
        q_crc_ok <= crc;
        @(posedge clock);
        q_frame_done <= 1'h0;
        q_crc_ok <= ~crc;
        @(posedge clock);
    endtask
    initial begin
        logic [6:0] codes [6];
        logic [7:0] word8;
        logic lwc;
        int k1, k2, t;
        codes = '{CODE_FLUSH, CODE_NORMAL, CODE_FAST, CODE_ENCODE, 7'h55, 7'h21};
        void'($urandom(61893));
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        check("reset outputs", {deint_flush, fifo_write_en, ecc_passes}, 5'h10);
        acc(STATUS_IDX, 1'h0, 32'h0, 32'h0);
        acc(MODE_IDX, 1'h0, 32'h0, 32'h0);
        acc(LEVEL_IDX, 1'h0, 32'h0, 32'h0);
        acc(8'h00, 1'h0, 32'h0, 32'h0);
        acc(ERR2_IDX, 1'h1, 32'h5A, 32'h0, 32'h0);
        laser_on_in <= 1'h1;
        write_on_in <= 1'h1;
        // Every mode code except hold, reserved ones too, with a random laser reset bit
        foreach (codes[i]) begin
            lwc = 1'($urandom);
            wr_mode(codes[i], lwc);
            check("mode", {deint_flush, fifo_write_en, ecc_passes}, exp_mode(codes[i]));
            check("laser", {laser_on, write_on}, {2{~lwc}});
        end
        pulse(0, 5);
        wr_mode(CODE_NORMAL, 1'h0);
        acc(LEVEL_IDX, 1'h0, 32'h0, SHARE_NORMAL);
        pulse(0, READ_MIN_FRAMES - 1);
        check("read ok low", fifo_read_ok, 1'h0);
        acc(LEVEL_IDX, 1'h0, 32'h0, READ_MIN_FRAMES - 1 + SHARE_NORMAL);
        pulse(0, 1);
        check("read ok high", fifo_read_ok, 1'h1);
        wr_mode(CODE_FAST, 1'h0);
        acc(LEVEL_IDX, 1'h0, 32'h0, READ_MIN_FRAMES + SHARE_FAST);
        wr_mode(CODE_HOLD, 1'h0);
        check("hold waits", fifo_write_en, 1'h1);
        pulse(2, 1);
        pulse(0, 4);
        check("hold", {fifo_write_en, fifo_read_ok}, 2'h1);
        pulse(1, 1);
        check("hold drain", fifo_read_ok, 1'h0);
        wr_mode(CODE_NORMAL, 1'h0);
        check("hold stays", fifo_write_en, 1'h0);
        pulse(2, 1);
        check("hold left", fifo_write_en, 1'h1);
        pulse(0, 1);
        wr_mode(CODE_FLUSH, 1'h0);
        acc(LEVEL_IDX, 1'h0, 32'h0, 32'h0);
        // Error counters: random counts, read clear, then saturation
        k1 = $urandom_range(40, 1);
        k2 = $urandom_range(40, 1);
        errs(k1, k2);
        acc(ERR1_IDX, 1'h0, 32'h0, k1);
        acc(ERR2_IDX, 1'h0, 32'h0, k2);
        acc(ERR1_IDX, 1'h0, 32'h0, 32'h0);
        errs(300, 256 + k2);
        acc(ERR1_IDX, 1'h0, 32'h0, ERR_MAX);
        acc(ERR2_IDX, 1'h0, 32'h0, ERR_MAX);
        // Subcode capture: status, bytes, release, with an overwrite attempt while held
        foreach (qb[i]) qb[i] = 8'($urandom);
        send_q(8'h00, 1'h1);
        acc(STATUS_IDX, 1'h0, 32'h0, 32'hA0);
        acc(STATUS_IDX, 1'h0, 32'h0, 32'hE0);
        send_q(8'hFF, 1'h0);
        foreach (qb[i]) acc(MODE_IDX, 1'h0, 32'h0, qb[i]);
        acc(MODE_IDX, 1'h0, 32'h0, 32'h0);
        acc(RELEASE_IDX, 1'h0, 32'h0, 32'h0);
        acc(STATUS_IDX, 1'h0, 32'h0, 32'h0, 32'hC0);
        send_q(8'h3C, 1'h0);
        acc(STATUS_IDX, 1'h0, 32'h0, 32'h80);
        acc(STATUS_IDX, 1'h0, 32'h0, 32'hC0, 32'hC0);
        acc(MODE_IDX, 1'h0, 32'h0, qb[0] ^ 8'h3C);
        acc(RELEASE_IDX, 1'h0, 32'h0, 32'h0);
        // Serial words: block start in the first forces a sync pause, then a plain gap
        for (int n = 0; n < 3; n++) begin
            word8 = {1'h1, 7'($urandom)};
            sub_word_valid <= 1'h1;
            sub_word <= word8[6:0];
            @(posedge clock);
            while (sub_word_ready !== 1'h1) @(posedge clock);
            sub_word_valid <= 1'h0;
            sub_word <= ~word8[6:0];
            t = 0;
            while (serial_subcode_pin !== 1'h1 && t < 2000) begin
                @(posedge clock);
                t++;
            end
            t = low_run * CLK_PERIOD_NS * 100;
            if (n < 2) check("sync pause", t >= SYNC_MIN_NS, 1'h1);
            else check("word gap", t >= GAP_MIN_NS && t <= GAP_MAX_NS, 1'h1);
            pul[2] <= n == 0;
            repeat (BITC / 2) @(posedge clock);
            for (int b = 7; b >= 0; b--) begin
                pul[2] <= 1'h0;
                check("serial bit", serial_subcode_pin, word8[b]);
                repeat (BITC) @(posedge clock);
            end
        end
        check("idle low", serial_subcode_pin, 1'h0);
        summarize();
    end
endmodule
